// >>> hdl/wws_windowed_supervisor.sv
// Purpose: window watchdog supervising an external microcontroller
// Assumes: inputs synchronous to ref_clk; cfg is written by the spi block
// Notes: all state but the reset synchronizer freezes while clkEn is low
`timescale 1ns/100ps

module wws_windowed_supervisor
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic clkEn,
   input wire logic enable,
   input wws_pkg::wws_cfg_s cfg,
   input wire logic cfgWrite,
   input wire logic spiTriggerCommandReg,
   input wire logic triggerInputPin,
   output logic mcuResetOutput_n,
   output logic regulatorEnable,
   output logic faultState,
   output logic irqRequest,
   output wws_pkg::wws_result_s windowResultSignal,
   output logic [wws_pkg::ERRW-1:0] errorCount,
   output wws_pkg::wws_state_e windowState
);
   import wws_pkg::*;

   // ----------------------------------------
   // reset release
   // ----------------------------------------
   logic rstMeta_q;
   logic rstSync_q;
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rstMeta_q <= 1'b0;
         rstSync_q <= 1'b0;
      end
      else
      begin
         rstMeta_q <= 1'b1;
         rstSync_q <= rstMeta_q;
      end
   end
   wire logic rstN = rstSync_q;

   // ----------------------------------------
   // base cycle tick and pin sample tick
   // ----------------------------------------
   logic [TICKW-1:0] preCnt_q;
   logic [SAMW-1:0] samCnt_q;
   logic baseTick;
   logic samTick;
   // restarting the prescaler with each window keeps window lengths exact,
   // at the cost of the pin sampler and the prescaler drifting apart
   logic winStart;
   wire logic [TICKW-1:0] cycClks = cfg.cycleTimeSelect ? TICKW'(CYC1_CLKS) : TICKW'(CYC0_CLKS);
   assign baseTick = clkEn && (preCnt_q >= cycClks - TICKW'(1));
   assign samTick = clkEn && (samCnt_q == SAMW'(SAMPLE_CLKS - 1));
   always_ff @(posedge ref_clk or negedge rstN)
   begin
      if (!rstN)
         preCnt_q <= '0;
      else if (clkEn)
      begin
         if (baseTick || winStart)
            preCnt_q <= '0;
         else
            preCnt_q <= preCnt_q + TICKW'(1);
      end
   end
   always_ff @(posedge ref_clk or negedge rstN)
   begin
      if (!rstN)
         samCnt_q <= '0;
      else if (clkEn)
         samCnt_q <= samTick ? '0 : samCnt_q + SAMW'(1);
   end

   // ----------------------------------------
   // pin trigger filter
   // ----------------------------------------
   // three stored samples plus the live one; the decision lands on the second low sample
   logic [2:0] pinHist_q;
   always_ff @(posedge ref_clk or negedge rstN)
   begin
      if (!rstN)
         pinHist_q <= 3'h0;
      else if (samTick)
         pinHist_q <= {pinHist_q[1:0], triggerInputPin};
   end
   wire logic pinTrig = samTick && (pinHist_q == 3'h6) && !triggerInputPin;

   // ----------------------------------------
   // trigger selection
   // ----------------------------------------
   wire wws_state_e state_q;
   wws_state_e stateR_q;
   assign state_q = stateR_q;
   wire logic inLong = (stateR_q == WWS_LONG_OPEN);
   // pin is ignored in the long open window; spi is default source
   wire logic trig = cfg.pinSource ? (pinTrig && !inLong) : (clkEn && spiTriggerCommandReg);

   // ----------------------------------------
   // window sequencer
   // ----------------------------------------
   logic [TICKW-1:0] winCnt_q;
   logic [TICKW-1:0] initCnt_q;
   logic [1:0] longFails_q;
   logic longInvalid_q;
   logic [ERRW-1:0] err_q;
   wire logic [TICKW-1:0] longTicks = cfg.cycleTimeSelect ? TICKW'(LONG_OPEN_TICKS)
                                                          : TICKW'(LONG_OPEN_TICKS);
   wire logic winEnd = baseTick && (
      (stateR_q == WWS_LONG_OPEN && winCnt_q >= longTicks - TICKW'(1)) ||
      (stateR_q == WWS_OPEN && winCnt_q >= TICKW'(cfg.openCycles) - TICKW'(1)) ||
      (stateR_q == WWS_CLOSED && winCnt_q >= TICKW'(cfg.closedCycles) - TICKW'(1)));
   wire logic initExpire = inLong && baseTick && initCnt_q >= TICKW'(INIT_TIMEOUT_TICKS - 1);
   wire logic porDone = stateR_q == WWS_SOFT_RST && baseTick
                        && winCnt_q >= TICKW'(POR_DELAY_TICKS - 1);
   logic resValid;
   logic resGood;
   wws_state_e stateNext;
   logic winRestart;

   always_comb
   begin
      stateNext = stateR_q;
      resValid = 1'b0;
      resGood = 1'b0;
      winRestart = 1'b0;
      case (stateR_q)
         WWS_OFF:
         begin
            if (enable && clkEn)
            begin
               stateNext = WWS_LONG_OPEN;
               winRestart = 1'b1;
            end
         end
         WWS_LONG_OPEN:
         begin
            if (cfgWrite && clkEn)
            begin
               stateNext = WWS_OPEN;
               winRestart = 1'b1;
            end
            else if (trig)
            begin
               stateNext = WWS_CLOSED;
               winRestart = 1'b1;
               resValid = 1'b1;
               resGood = 1'b1;
            end
            else if (initExpire && (longInvalid_q || winEnd))
            begin
               // the timeout wins over the window end, so its interrupt is skipped
               winRestart = 1'b1;
               stateNext = (longFails_q + 2'h1 >= LONG_OPEN_LIMIT) ? WWS_FAULT
                                                                  : WWS_SOFT_RST;
            end
            else if (winEnd)
            begin
               winRestart = 1'b1;
               resValid = 1'b1;
            end
         end
         WWS_CLOSED:
         begin
            if (trig)
            begin
               stateNext = WWS_OPEN;
               winRestart = 1'b1;
               resValid = 1'b1;
            end
            else if (winEnd)
            begin
               stateNext = WWS_OPEN;
               winRestart = 1'b1;
            end
         end
         WWS_OPEN:
         begin
            if (trig)
            begin
               stateNext = WWS_CLOSED;
               winRestart = 1'b1;
               resValid = 1'b1;
               resGood = 1'b1;
            end
            else if (winEnd)
            begin
               winRestart = 1'b1;
               resValid = 1'b1;
            end
         end
         WWS_SOFT_RST:
         begin
            if (porDone)
            begin
               stateNext = WWS_LONG_OPEN;
               winRestart = 1'b1;
            end
         end
         // terminal until nrst; the regulators stay off meanwhile
         WWS_FAULT:
            stateNext = WWS_FAULT;
         default:
            stateNext = WWS_OFF;
      endcase
   end

   // one spare bit keeps a count near the top from wrapping past the threshold
   wire logic [ERRW:0] errSum = {1'b0, err_q} + {1'b0, ERR_INC};
   wire logic errOverflow = resValid && !resGood && (errSum >= {1'b0, cfg.errorCountThreshold});
   assign winStart = winRestart || errOverflow;

   always_ff @(posedge ref_clk or negedge rstN)
   begin
      if (!rstN)
         stateR_q <= WWS_OFF;
      else if (clkEn)
      begin
         if (errOverflow && stateNext != WWS_FAULT)
            stateR_q <= WWS_SOFT_RST;
         else
            stateR_q <= stateNext;
      end
   end

   always_ff @(posedge ref_clk or negedge rstN)
   begin
      if (!rstN)
         winCnt_q <= '0;
      else if (clkEn)
      begin
         if (winStart)
            winCnt_q <= '0;
         else if (baseTick)
            winCnt_q <= winCnt_q + TICKW'(1);
      end
   end

   // init timer runs across the long open window only
   always_ff @(posedge ref_clk or negedge rstN)
   begin
      if (!rstN)
         initCnt_q <= '0;
      else if (clkEn)
      begin
         if (!inLong || stateNext != WWS_LONG_OPEN)
            initCnt_q <= '0;
         else if (baseTick)
            initCnt_q <= initCnt_q + TICKW'(1);
      end
   end

   always_ff @(posedge ref_clk or negedge rstN)
   begin
      if (!rstN)
      begin
         longInvalid_q <= 1'b0;
         longFails_q <= 2'h0;
      end
      else if (clkEn)
      begin
         if (inLong && winEnd && !trig)
            longInvalid_q <= 1'b1;
         else if (stateNext != WWS_LONG_OPEN)
            longInvalid_q <= 1'b0;
         if (inLong && (stateNext == WWS_SOFT_RST))
            longFails_q <= longFails_q + 2'h1;
         else if (inLong && (stateNext == WWS_CLOSED || stateNext == WWS_OPEN))
            longFails_q <= 2'h0;
      end
   end

   // ----------------------------------------
   // error counter and result
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rstN)
   begin
      if (!rstN)
         err_q <= ERR_ZERO;
      else if (clkEn && resValid)
      begin
         if (!resGood)
            err_q <= errOverflow ? ERR_ZERO : errSum[ERRW-1:0];
         else if (err_q != ERR_ZERO)
            err_q <= err_q - ERR_DEC;
      end
   end

   always_ff @(posedge ref_clk or negedge rstN)
   begin
      if (!rstN)
      begin
         windowResultSignal <= '0;
         irqRequest <= 1'b0;
      end
      else if (clkEn)
      begin
         windowResultSignal.valid <= resValid;
         windowResultSignal.good <= resGood;
         irqRequest <= resValid && !resGood;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign mcuResetOutput_n = (stateR_q != WWS_SOFT_RST) && (stateR_q != WWS_FAULT);
   assign regulatorEnable = (stateR_q != WWS_FAULT);
   assign faultState = (stateR_q == WWS_FAULT);
   assign errorCount = err_q;
   assign windowState = state_q;

endmodule

// >>> common/wws_pkg.sv
// Purpose: shared constants and types for the windowed supervisor
// Assumes: 200 MHz ref_clk
// Notes: times are kept in their own unit; cycle counts derive from them
package wws_pkg;

   // ----------------------------------------
   // clock and timing
   // ----------------------------------------
   localparam int CLK_MHZ = 200;
   localparam int CYC0_NS = 10000;   // cycle time, selector 0
   localparam int CYC1_NS = 100000;  // cycle time, selector 1
   localparam int SAMPLE_NS = 400000; // trigger pin sampling period
   localparam int LONG_OPEN_MS1 = 600;
   localparam int LONG_OPEN_MS0 = 60;
   localparam int CYC0_CLKS = CYC0_NS * CLK_MHZ / 1000;
   localparam int CYC1_CLKS = CYC1_NS * CLK_MHZ / 1000;
   localparam int SAMPLE_CLKS = SAMPLE_NS * CLK_MHZ / 1000;
   // long open window measured in base ticks: 6000 ticks of either cycle time
   localparam int LONG_OPEN_TICKS = LONG_OPEN_MS1 * 1000000 / CYC1_NS;
   localparam int INIT_TIMEOUT_TICKS = LONG_OPEN_TICKS;
   localparam int POR_DELAY_TICKS = 100;

   // ----------------------------------------
   // widths and reset values
   // ----------------------------------------
   localparam int TICKW = 16;
   localparam int SAMW = $clog2(SAMPLE_CLKS);
   localparam int WINW = 8;
   localparam int ERRW = 5;
   localparam logic [WINW-1:0] OPEN_CYC_RST = 8'h10;
   localparam logic [WINW-1:0] CLOSED_CYC_RST = 8'h08;
   localparam logic [ERRW-1:0] ERR_THR_RST = 5'h0A;
   localparam logic [ERRW-1:0] ERR_INC = 5'h02;
   localparam logic [ERRW-1:0] ERR_DEC = 5'h01;
   localparam logic [ERRW-1:0] ERR_ZERO = 5'h00;
   localparam logic [1:0] LONG_OPEN_LIMIT = 2'h2;

   typedef enum logic [2:0] {
      WWS_OFF = 3'b000,
      WWS_LONG_OPEN = 3'b001,
      WWS_CLOSED = 3'b010,
      WWS_OPEN = 3'b011,
      WWS_SOFT_RST = 3'b100,
      WWS_FAULT = 3'b101
   } wws_state_e;

   typedef struct packed {
      logic pinSource;               // 1: trigger pin, 0: spi command
      logic cycleTimeSelect;         // 1: slow cycle, 0: fast cycle
      logic [WINW-1:0] openCycles;
      logic [WINW-1:0] closedCycles;
      logic [ERRW-1:0] errorCountThreshold;
   } wws_cfg_s;

   typedef struct packed {
      logic valid;   // one-cycle pulse per decision
      logic good;    // 1: valid triggering, 0: invalid
   } wws_result_s;

endpackage

// >>> verification/wws_windowed_supervisor_chk.sv
// Purpose: port assertions for the windowed supervisor
// Assumes: single ref_clk domain
// Notes: pin trigger path is not watched; its filter is too slow for a short run
`timescale 1ns/100ps
module wws_windowed_supervisor_chk
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic clkEn,
   input wws_pkg::wws_cfg_s cfg,
   input wire logic cfgWrite,
   input wire logic spiTriggerCommandReg,
   input wire logic mcuResetOutput_n,
   input wire logic regulatorEnable,
   input wire logic faultState,
   input wire logic irqRequest,
   input wws_pkg::wws_result_s windowResultSignal,
   input wire logic [wws_pkg::ERRW-1:0] errorCount,
   input wws_pkg::wws_state_e windowState
);
   import wws_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // in the long open window a config write in the same cycle takes precedence, so it is left out
   wire logic spiGo = spiTriggerCommandReg && clkEn && !cfg.pinSource && !cfgWrite;
   sequence trigIn(wws_state_e s);
      windowState == s && spiGo;
   endsequence
   sequence badResult;
      ##[1:2] windowResultSignal.valid && !windowResultSignal.good;
   endsequence
   AST_IRQ_INVALID: assert property (irqRequest == (windowResultSignal.valid &&
      !windowResultSignal.good)) else $error("irq not matched to invalid result");
   AST_ERR_STEP: assert property (errorCount != $past(errorCount) |->
      errorCount == $past(errorCount) + ERR_INC || errorCount == ERR_ZERO ||
      ($past(errorCount) != ERR_ZERO && errorCount == $past(errorCount) - ERR_DEC))
      else $error("error counter moved by a wrong step");
   AST_REG_FAULT: assert property (regulatorEnable == !faultState)
      else $error("regulator enable differs from fault");
   AST_RST_OUT: assert property (mcuResetOutput_n ==
      !(windowState == WWS_SOFT_RST || windowState == WWS_FAULT))
      else $error("reset output wrong for state");
   AST_LONG_TRIG: assert property (trigIn(WWS_LONG_OPEN) |=> windowState == WWS_CLOSED)
      else $error("trigger in long window did not close");
   AST_CLOSED_BAD: assert property (trigIn(WWS_CLOSED) |-> badResult)
      else $error("trigger in closed window not invalid");
   AST_CLOSED_NEXT: assert property (trigIn(WWS_CLOSED) |=>
      windowState inside {WWS_OPEN, WWS_SOFT_RST}) else $error("closed trigger next state");
   AST_OPEN_TRIG: assert property (trigIn(WWS_OPEN) |=> windowState == WWS_CLOSED
      ##[0:1] windowResultSignal.valid && windowResultSignal.good)
      else $error("open trigger not valid or not closing");
   AST_CFG_RESTART: assert property (windowState == WWS_LONG_OPEN && cfgWrite && clkEn
      |=> windowState == WWS_OPEN) else $error("config write did not restart");
endmodule
bind wws_windowed_supervisor wws_windowed_supervisor_chk chk (.ref_clk(ref_clk), .nrst(nrst),
   .clkEn(clkEn), .cfg(cfg), .cfgWrite(cfgWrite), .spiTriggerCommandReg(spiTriggerCommandReg),
   .mcuResetOutput_n(mcuResetOutput_n), .regulatorEnable(regulatorEnable),
   .faultState(faultState), .irqRequest(irqRequest), .windowResultSignal(windowResultSignal),
   .errorCount(errorCount), .windowState(windowState));

// >>> verification/wws_mcu_model.sv
// Purpose: microcontroller stand-in giving spi command writes and the trigger pin
// Assumes: bench requests change at the falling edge
// Notes: an undriven pin reads low because of its pull-down
`timescale 1ns/100ps
module wws_mcu_model
(
   input wire logic ref_clk,
   input wire logic kickReq,
   input wire logic pinDriveEn,
   input wire logic pinLevel,
   output logic spiTriggerCommandReg,
   output logic triggerInputPin
);
   // one command write per request cycle, launched off the falling edge
   always_ff @(negedge ref_clk)
   begin
      spiTriggerCommandReg <= kickReq;
   end
   assign triggerInputPin = pinDriveEn ? pinLevel : 1'b0;
endmodule

// >>> verification/test_wws_windowed_supervisor.sv
// Purpose: self-checking bench for the windowed supervisor
// Assumes: fast cycle time, one closed tick and two open ticks
// Notes: long window expiry and the pin filter are too slow to run out here
`timescale 1ns/100ps
module test_wws_windowed_supervisor;
   import wws_pkg::*;
   localparam int TICK = CYC0_CLKS;
   localparam int LIMIT = 40000;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic enable = 1'b0;
   logic cfgWrite = 1'b0;
   logic kickReq = 1'b0;
   logic clkEn = 1'b1;
   logic spiTrig, pin, mcuResetOutput_n, regulatorEnable, faultState, irqRequest;
   wws_cfg_s cfg = '{1'b0, 1'b0, 8'h02, 8'h01, ERR_THR_RST};
   wws_result_s res;
   logic [ERRW-1:0] errorCount;
   wws_state_e state;
   int errors = 0;
   int checked = 0;
   int cycles = 0;
   initial
   begin
      forever #2.5 ref_clk = ~ref_clk;
   end
   wws_windowed_supervisor DUT (.ref_clk(ref_clk), .nrst(nrst), .clkEn(clkEn), .enable(enable),
      .cfg(cfg), .cfgWrite(cfgWrite), .spiTriggerCommandReg(spiTrig), .triggerInputPin(pin),
      .mcuResetOutput_n(mcuResetOutput_n), .regulatorEnable(regulatorEnable),
      .faultState(faultState), .irqRequest(irqRequest), .windowResultSignal(res),
      .errorCount(errorCount), .windowState(state));
   wws_mcu_model mcu (.ref_clk(ref_clk), .kickReq(kickReq), .pinDriveEn(1'b0),
      .pinLevel(1'b0), .spiTriggerCommandReg(spiTrig), .triggerInputPin(pin));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic final_report();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
      begin
         $display("== PASSED ==");
      end
      else
      begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         errors++;
         $display("BAD %0t timeout", $time);
         final_report();
      end
   end
   task automatic chk(input logic ok, input string msg);
      checked++;
      if (ok !== 1'b1)
      begin
         errors++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask
   task automatic waitState(input wws_state_e s, input int maxCyc, output int n);
      n = 0;
      while (state !== s && n < maxCyc)
      begin
         @(negedge ref_clk);
         n++;
      end
   endtask
   task automatic doReset();
      enable <= 1'b0;
      nrst <= 1'b0;
      repeat (3) @(negedge ref_clk);
      nrst <= 1'b1;
      repeat (3) @(negedge ref_clk);
   endtask
   // result is registered on the decision edge, together with the state change
   task automatic trig(input logic g, input wws_state_e s, input logic [ERRW-1:0] e);
      logic seen;
      seen = 1'b0;
      kickReq <= 1'b1;
      @(negedge ref_clk);
      kickReq <= 1'b0;
      repeat (4)
      begin
         @(negedge ref_clk);
         if (res.valid === 1'b1 && !seen)
         begin
            seen = 1'b1;
            chk(res.good === g && irqRequest === !g, "result kind");
         end
      end
      chk(seen && state === s && errorCount === e, "state or count after trigger");
   endtask
   initial
   begin
      int n;
      doReset();
      chk(state === WWS_OFF && mcuResetOutput_n === 1'b1 && regulatorEnable === 1'b1 &&
         faultState === 1'b0 && irqRequest === 1'b0 && errorCount === ERR_ZERO, "reset values");
      enable <= 1'b1;
      waitState(WWS_LONG_OPEN, 5, n);
      chk(state === WWS_LONG_OPEN, "long window not opened");
      cfgWrite <= 1'b1;
      @(negedge ref_clk);
      cfgWrite <= 1'b0;
      @(negedge ref_clk);
      chk(state === WWS_OPEN, "no restart after config");
      doReset();
      enable <= 1'b1;
      waitState(WWS_LONG_OPEN, 5, n);
      trig(1'b1, WWS_CLOSED, ERR_ZERO);
      trig(1'b0, WWS_OPEN, 5'h02);
      trig(1'b1, WWS_CLOSED, 5'h01);
      waitState(WWS_OPEN, 3 * TICK, n);
      chk(n + 4 >= TICK - 10 && n + 4 <= TICK + 10, "closed length");
      n = 0;
      while (res.valid !== 1'b1 && n < 6 * TICK)
      begin
         @(negedge ref_clk);
         n++;
      end
      chk(n >= 2 * TICK - 10 && n <= 2 * TICK + 10 && res.good === 1'b0, "open expiry");
      repeat (2) @(negedge ref_clk);
      chk(state === WWS_OPEN && errorCount === 5'h03, "after expiry");
      for (int k = 2; k >= 0; k--)
      begin
         trig(1'b1, WWS_CLOSED, k[ERRW-1:0]);
         waitState(WWS_OPEN, 3 * TICK, n);
      end
      trig(1'b1, WWS_CLOSED, ERR_ZERO);
      // a frozen block must ignore a command that lands while clkEn is low
      clkEn <= 1'b0;
      kickReq <= 1'b1;
      @(negedge ref_clk);
      kickReq <= 1'b0;
      repeat (4) @(negedge ref_clk);
      chk(state === WWS_CLOSED && errorCount === ERR_ZERO && res.valid === 1'b0, "freeze");
      clkEn <= 1'b1;
      cfg.errorCountThreshold <= 5'h02;
      @(negedge ref_clk);
      trig(1'b0, WWS_SOFT_RST, ERR_ZERO);
      chk(mcuResetOutput_n === 1'b0 && regulatorEnable === 1'b1 &&
         faultState === 1'b0, "soft reset outputs");
      final_report();
   end
endmodule
